// file: verilog/pic_pkg.sv
// Constants and register map for the pulse interval capture channel
package pic_pkg;
	localparam int PIC_CNT_W = 16;
	localparam int PIC_PSC_W = 2;
	localparam logic [PIC_PSC_W-1:0] PIC_PSC_LAST = 2'h3;
	localparam logic [PIC_CNT_W-1:0] PIC_CNT_ZERO = 16'h0000;
	localparam logic [PIC_CNT_W-1:0] PIC_CNT_MAX = 16'hFFFF;
	localparam logic [11:0] PIC_ADDR_CTRL = 12'h000;
	localparam logic [11:0] PIC_ADDR_STAT = 12'h004;
	localparam logic [11:0] PIC_ADDR_CAPT = 12'h008;
	localparam logic [11:0] PIC_ADDR_COUNT = 12'h00C;
	localparam int PIC_CTRL_START = 0;
	localparam int PIC_CTRL_STOP = 1;
	localparam int PIC_STAT_RUN = 0;
	localparam int PIC_STAT_CAPT = 1;
	localparam int PIC_STAT_OVF = 2;
	localparam int PIC_STAT_CAPOVF = 3;
	localparam logic [31:0] PIC_RD_ZERO = 32'h0000_0000;
	typedef enum logic [1:0] {PIC_IDLE, PIC_RUN} pic_state_t;
endpackage : pic_pkg

// file: verilog/pic_sync.sv
// Three-stage input synchroniser with agreement-based rising edge detect
`timescale 1ns/1ps
module pic_sync (
	input wire logic clk_i, // Clock
	input wire logic rst_b_i, // Async reset, active low
	input wire logic async_i, // Pin level
	output logic rise_o // One-cycle pulse on agreed rise
);
	logic [2:0] sync_q;
	logic [2:0] sync_d;
	logic lvl_q;
	logic lvl_d;
	logic rise_q;
	logic rise_d;
	always_comb begin
		sync_d = {sync_q[1:0], async_i};
		lvl_d = lvl_q;
		// Level changes only once stages two and three agree
		if (sync_q[1] == sync_q[2]) begin
			lvl_d = sync_q[2];
		end
		rise_d = lvl_d & ~lvl_q;
	end
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync_q <= 3'h0;
			lvl_q <= 1'b0;
			rise_q <= 1'b0;
		end else begin
			sync_q <= sync_d;
			lvl_q <= lvl_d;
			rise_q <= rise_d;
		end
	end
	assign rise_o = rise_q;
endmodule : pic_sync

// file: verilog/pic_capture.sv
// Pulse interval capture channel with APB register access
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
module pic_capture
	import pic_pkg::*;
#(
	parameter int CNT_W = PIC_CNT_W // Counter width
) (
	input wire logic clk_i, // 20 MHz clock
	input wire logic rst_b_i, // Async reset, active low
	input wire logic psel_i, // APB select
	input wire logic penable_i, // APB enable
	input wire logic pwrite_i, // APB direction
	input wire logic [11:0] paddr_i, // APB byte address
	input wire logic [31:0] pwdata_i, // APB write data
	output logic [31:0] prdata_o, // APB read data
	output logic pready_o, // APB ready
	output logic pslverr_o, // APB error
	input wire logic pulse_input_pin, // Pulse input pin
	output logic channel_capture_irq_o // One-cycle capture interrupt
);
	pic_state_t state_q, state_d;
	logic [PIC_PSC_W-1:0] psc_q, psc_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CNT_W-1:0] capt_q, capt_d;
	logic ovf_q, ovf_d;
	logic capovf_q, capovf_d;
	logic captf_q, captf_d;
	logic irq_q, irq_d;
	logic [31:0] rdata_q, rdata_d;
	logic ready_q, ready_d;
	logic err_q, err_d;
	logic edge_rise;
	logic tick;
	logic acc;
	logic wr;
	logic rd;
	logic start_wr;
	logic stop_wr;
	logic stat_rd;

	function automatic logic addr_ok(input logic [11:0] a);
		addr_ok = (a == PIC_ADDR_CTRL) || (a == PIC_ADDR_STAT) ||
			(a == PIC_ADDR_CAPT) || (a == PIC_ADDR_COUNT);
	endfunction : addr_ok

	pic_sync u_sync (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.async_i(pulse_input_pin),
		.rise_o(edge_rise)
	);

	// One-cycle wait state: access answered in the second access cycle
	assign acc = psel_i & penable_i & ready_q;
	assign wr = acc & pwrite_i;
	assign rd = acc & ~pwrite_i;
	assign start_wr = wr && (paddr_i == PIC_ADDR_CTRL) && pwdata_i[PIC_CTRL_START];
	assign stop_wr = wr && (paddr_i == PIC_ADDR_CTRL) && pwdata_i[PIC_CTRL_STOP];
	// Clear on the cycle the status word is latched, so a later event is never lost
	assign stat_rd = psel_i & penable_i & ~ready_q & ~pwrite_i && (paddr_i == PIC_ADDR_STAT);
	assign tick = (state_q == PIC_RUN) && (psc_q == PIC_PSC_LAST);

	always_comb begin
		state_d = state_q;
		psc_d = psc_q + 1'b1;
		cnt_d = cnt_q;
		capt_d = capt_q;
		ovf_d = ovf_q;
		capovf_d = capovf_q;
		captf_d = captf_q;
		irq_d = 1'b0;
		// Status read clears sticky flags; a new event in the same cycle wins
		if (stat_rd) begin
			ovf_d = 1'b0;
			captf_d = 1'b0;
		end
		case (state_q)
			PIC_IDLE: begin
				psc_d = '0;
			end
			PIC_RUN: begin
				if (edge_rise) begin
					capt_d = cnt_q;
					capovf_d = ovf_q;
					captf_d = 1'b1;
					irq_d = 1'b1;
					cnt_d = PIC_CNT_ZERO[CNT_W-1:0];
					ovf_d = 1'b0;
				end else if (tick) begin
					cnt_d = cnt_q + 1'b1;
					if (cnt_q == PIC_CNT_MAX[CNT_W-1:0]) begin
						ovf_d = 1'b1;
					end
				end
				if (stop_wr) begin
					state_d = PIC_IDLE;
				end
			end
			default: begin
				state_d = PIC_IDLE;
			end
		endcase
		if (start_wr) begin
			state_d = PIC_RUN;
			cnt_d = PIC_CNT_ZERO[CNT_W-1:0];
			psc_d = '0;
			ovf_d = 1'b0;
		end
	end

	always_comb begin
		ready_d = psel_i & penable_i & ~ready_q;
		err_d = 1'b0;
		rdata_d = PIC_RD_ZERO;
		if (psel_i & penable_i & ~ready_q) begin
			err_d = ~addr_ok(paddr_i);
			if (!pwrite_i) begin
				if (paddr_i == PIC_ADDR_STAT) begin
					rdata_d[PIC_STAT_RUN] = (state_q == PIC_RUN);
					rdata_d[PIC_STAT_CAPT] = captf_q;
					rdata_d[PIC_STAT_OVF] = ovf_q;
					rdata_d[PIC_STAT_CAPOVF] = capovf_q;
				end else if (paddr_i == PIC_ADDR_CAPT) begin
					rdata_d[CNT_W-1:0] = capt_q;
				end else if (paddr_i == PIC_ADDR_COUNT) begin
					rdata_d[CNT_W-1:0] = cnt_q;
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= PIC_IDLE;
			psc_q <= '0;
			cnt_q <= '0;
			capt_q <= '0;
			ovf_q <= 1'b0;
			capovf_q <= 1'b0;
			captf_q <= 1'b0;
			irq_q <= 1'b0;
			rdata_q <= PIC_RD_ZERO;
			ready_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			state_q <= state_d;
			psc_q <= psc_d;
			cnt_q <= cnt_d;
			capt_q <= capt_d;
			ovf_q <= ovf_d;
			capovf_q <= capovf_d;
			captf_q <= captf_d;
			irq_q <= irq_d;
			rdata_q <= rdata_d;
			ready_q <= ready_d;
			err_q <= err_d;
		end
	end

	assign prdata_o = rdata_q;
	assign pready_o = ready_q;
	assign pslverr_o = err_q;
	assign channel_capture_irq_o = irq_q;

	sequence start_seq;
		start_wr;
	endsequence
	sequence cleared_seq;
		(cnt_q == PIC_CNT_ZERO) && (state_q == PIC_RUN);
	endsequence

	start_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		start_seq |=> cleared_seq)
		else $error("Counter not cleared after start");
	capture_copy_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(edge_rise && state_q == PIC_RUN && !start_wr) |=> (capt_q == $past(cnt_q)))
		else $error("Capture did not copy the counter");
	capture_irq_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(edge_rise && state_q == PIC_RUN) |=> channel_capture_irq_o ##1 !channel_capture_irq_o)
		else $error("Interrupt not a single pulse after capture");
	irq_cause_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		channel_capture_irq_o |-> $past(edge_rise) && $past(state_q == PIC_RUN))
		else $error("Interrupt without a capture");
	restart_zero_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(edge_rise && state_q == PIC_RUN) |=> cnt_q == PIC_CNT_ZERO)
		else $error("Counter not restarted after capture");
	keep_count_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(state_q == PIC_RUN && !edge_rise && !start_wr && !stop_wr)[*5] |->
		cnt_q != $past(cnt_q, 4))
		else $error("Counter stalled while running");
	wrap_flag_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(tick && !edge_rise && !start_wr && cnt_q == PIC_CNT_MAX[CNT_W-1:0]) |=>
		ovf_q && cnt_q == PIC_CNT_ZERO)
		else $error("Wrap did not flag overflow");
	prescale_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(state_q == PIC_RUN && !edge_rise && !start_wr) ##1 $changed(cnt_q) |->
		$past(tick))
		else $error("Counter moved off the divided clock");
	idle_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(state_q == PIC_IDLE && !start_wr) |=> $stable(cnt_q))
		else $error("Counter moved while stopped");
endmodule : pic_capture

// file: verif/pic_pulse_src.sv
// Pulse source model feeding the capture pin
`timescale 1ns/1ps
module pic_pulse_src (
	input wire logic clk_i, // Clock
	input wire logic go_i, // Emit pulses while high
	input wire logic [31:0] gap_i, // Cycles between rising edges
	output logic pin_o // Pulse pin
);
	int n = 0;
	always @(posedge clk_i) begin
		n <= (!go_i || n >= int'(gap_i) - 1) ? 0 : n + 1;
		pin_o <= go_i && n < 8;
	end
endmodule : pic_pulse_src

// file: verif/testbench.sv
// Self-checking bench for the pulse interval capture channel
`timescale 1ns/1ps
module testbench;
	import pic_pkg::*;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, r;
	logic pready, pslverr, irq, pin, e;
	int gap = 48, g, mismatches = 0, n_compared = 0;
	pic_capture #(.CNT_W(8)) i_pic_capture (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.pulse_input_pin(pin), .channel_capture_irq_o(irq));
	pic_pulse_src i_pic_pulse_src (.clk_i(clk_i), .go_i(go), .gap_i(gap), .pin_o(pin));
	initial forever #25 clk_i = ~clk_i;
	task automatic end_sim;
		if (mismatches == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	task automatic chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask : chk
	// One APB transfer, held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do begin
			@(posedge clk_i);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			mismatches++;
			$display("unexpected at %0t: no ready", $time);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_irq;
		int k;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (irq !== 1'b1 && k < 3000);
		chk(k < 3000, "no capture interrupt");
	endtask : wait_irq
	// Ticks of the divided clock over g cycles, one may be lost at the restart
	function automatic logic near(input int t, input logic [31:0] v);
		return v >= t / 4 - 1 && v <= t / 4;
	endfunction : near
	initial begin
		void'($urandom(32'h1599));
		repeat (10) @(posedge clk_i);
		rst_b_i <= 1'b1;
		apb(1'b0, PIC_ADDR_STAT, 32'h0);
		chk(r === PIC_RD_ZERO && e === 1'b0, "status after reset");
		apb(1'b0, PIC_ADDR_CAPT, 32'h0);
		chk(r === PIC_RD_ZERO, "capture after reset");
		apb(1'b1, 12'h010, 32'hFFFF_FFFF);
		chk(e === 1'b1, "unmapped write");
		apb(1'b0, 12'h010, 32'h0);
		chk(e === 1'b1 && r === PIC_RD_ZERO, "unmapped read");
		for (int i = 0; i < 2; i++) begin
			// Second start also sets stop: start must win
			apb(1'b1, PIC_ADDR_CTRL, (i == 0) ? 32'h0000_0001 : 32'h0000_0003);
			apb(1'b0, PIC_ADDR_COUNT, 32'h0);
			chk(r <= 32'h1, "count after start");
			repeat (40) @(posedge clk_i);
			apb(1'b0, PIC_ADDR_COUNT, 32'h0);
			chk(r >= 32'h9 && r <= 32'hD, "count rate");
		end
		go <= 1'b1;
		// First capture holds no interval and is dropped
		wait_irq();
		for (int i = 0; i < 8; i++) begin
			g = (i == 7) ? 1100 : 48 + 4 * int'($urandom % 200);
			gap <= g;
			wait_irq();
			apb(1'b0, PIC_ADDR_CAPT, 32'h0);
			chk(near(i == 7 ? g - 1024 : g, r), "captured interval");
			apb(1'b0, PIC_ADDR_STAT, 32'h0);
			chk(r[PIC_STAT_CAPT] === 1'b1 && r[PIC_STAT_RUN] === 1'b1, "status");
			chk(r[PIC_STAT_CAPOVF] === (i == 7), "overflow flag");
		end
		go <= 1'b0;
		apb(1'b1, PIC_ADDR_CTRL, 32'h0000_0002);
		apb(1'b0, PIC_ADDR_STAT, 32'h0);
		chk(r[PIC_STAT_RUN] === 1'b0, "stop");
		end_sim();
	end
	initial begin
		repeat (50000) @(posedge clk_i);
		mismatches++;
		end_sim();
	end
endmodule : testbench
